// ===== design/icps_order_decode.sv
// icps_order_decode: splits a program command word into order, flags and count.
// assumes the command word is held stable by the sequencer while decoded.
`timescale 1ns/1ps
module icps_order_decode (
	input  wire logic [15:0]              cmd_word_in,
	output icps_pkg::icps_order_t         order_out,
	output logic                          chain_flag_out,
	output logic                          cond_flag_out,
	output logic [icps_pkg::COUNT_W-1:0]  count_out
);
	wire [2:0] code = cmd_word_in[icps_pkg::ORDER_HI:icps_pkg::ORDER_LO];

	assign chain_flag_out = cmd_word_in[icps_pkg::CHAIN_POS];
	assign cond_flag_out  = cmd_word_in[icps_pkg::COND_POS];
	assign count_out      = cmd_word_in[icps_pkg::COUNT_W-1:0];

	always_comb begin
		case (code)
			icps_pkg::ORD_JUMP:    order_out = icps_pkg::ORDER_JUMP;
			icps_pkg::ORD_RESIDUE: order_out = icps_pkg::ORDER_RESIDUE;
			icps_pkg::ORD_INTR:    order_out = icps_pkg::ORDER_INTR;
			icps_pkg::ORD_END:     order_out = icps_pkg::ORDER_END;
			icps_pkg::ORD_CONTROL: order_out = icps_pkg::ORDER_CONTROL;
			icps_pkg::ORD_SENSE:   order_out = icps_pkg::ORDER_SENSE;
			icps_pkg::ORD_WRITE:   order_out = icps_pkg::ORDER_WRITE;
			default:               order_out = icps_pkg::ORDER_READ;
		endcase
	end
endmodule : icps_order_decode

// ===== design/icps_top.sv
// icps_top: channel program sequencer; fetches and executes program double words.
// assumes a single-word memory port with ack, and device handshakes synchronous to core_clk_in.
// Summary of operation
// - step is command word then operand word
// - chain flag on write/read enables chaining
// - chained like orders continue one transfer
// - count is negative word count, twelve bits
// - code 000 jumps, conditional when bit set
// - code 001 stores remaining count in operand
// - code 010 raises cpu interrupt request
// - code 011 ends, stores status, optional interrupt
// - code 100 sends 28 control bits out
// - sense copies device status into operand
// - code 110 moves memory words to device
// - read moves device words into memory
// - start writes stack top as pointer
// - start loads device number and command
// - start forwarded to controller, runs independently
// - table entry at device number times four
// - multiplexer fetches pointer on channel demand
// - pointer advances per step, kept per mode
// - selector writes pointer back at completion
`timescale 1ns/1ps
module icps_top (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	// register bus
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	// main memory
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic [15:0]      mem_addr_out,
	output logic [15:0]      mem_wdata_out,
	input  wire logic [15:0] mem_rdata_in,
	input  wire logic        mem_ack_in,
	// channel and device controller
	input  wire logic        chan_demand_in,
	output logic             dev_start_out,
	output logic [7:0]       dev_num_out,
	input  wire logic        dev_jump_ok_in,
	input  wire logic [15:0] dev_status_in,
	output logic             dev_ctrl_valid_out,
	output logic [27:0]      dev_ctrl_data_out,
	output logic             dev_xfer_active_out,
	output logic             dev_xfer_read_out,
	output logic             dev_wvalid_out,
	output logic [15:0]      dev_wdata_out,
	input  wire logic        dev_wready_in,
	input  wire logic        dev_rvalid_in,
	input  wire logic [15:0] dev_rdata_in,
	output logic             dev_rready_out,
	output logic             cpu_irq_out,
	output logic             prog_done_out
);
	icps_pkg::icps_state_t state_reg;
	icps_pkg::icps_state_t ret_reg;
	icps_pkg::icps_order_t order;

	logic [15:0] ptr_reg;
	logic [15:0] step_reg;
	logic [15:0] cmd_reg;
	logic [15:0] oper_reg;
	logic [15:0] data_addr_reg;
	logic [11:0] count_reg;
	logic [15:0] mem_addr_reg;
	logic [15:0] mem_wdata_reg;
	logic        mem_we_reg;
	logic [15:0] rdata_reg;
	logic        chain_reg;
	logic        xfer_reg;
	logic        xfer_read_reg;
	logic        start_pulse_reg;
	logic        ctrl_valid_reg;
	logic [27:0] ctrl_data_reg;
	logic        irq_reg;
	logic        done_reg;
	logic [15:0] wdata_reg;
	logic [7:0]  dev_latch_reg;

	wire [7:0]  reg_dev_num;
	wire [15:0] reg_tos;
	wire        selector_mode;
	wire        start_req;
	wire        chain_flag;
	wire        cond_flag;
	wire [11:0] cmd_count;
	wire        busy = (state_reg != icps_pkg::ST_IDLE);

	// table entry address = device number times four
	wire [15:0] table_addr = {6'h00, dev_latch_reg, 2'b00};
	wire [11:0] count_inc  = count_reg + 12'h001;
	wire        count_last = (count_inc == 12'h000);
	wire        jump_taken = ~cond_flag | dev_jump_ok_in;
	wire        is_xfer    = (order == icps_pkg::ORDER_WRITE) | (order == icps_pkg::ORDER_READ);
	wire        same_dir   = xfer_read_reg == (order == icps_pkg::ORDER_READ);
	// a chained like order keeps the transfer open without a new start
	wire        chain_cont = chain_reg & xfer_reg & is_xfer & same_dir;

	icps_wb_regs u_regs (
		.core_clk_in       (core_clk_in),
		.rst_in            (rst_in),
		.wb_cyc_in         (wb_cyc_in),
		.wb_stb_in         (wb_stb_in),
		.wb_we_in          (wb_we_in),
		.wb_adr_in         (wb_adr_in),
		.wb_sel_in         (wb_sel_in),
		.wb_dat_in         (wb_dat_in),
		.wb_dat_out        (wb_dat_out),
		.wb_ack_out        (wb_ack_out),
		.busy_in           (busy),
		.chain_in          (chain_reg),
		.ptr_in            (ptr_reg),
		.count_in          (count_reg),
		.dev_num_out       (reg_dev_num),
		.tos_out           (reg_tos),
		.selector_mode_out (selector_mode),
		.start_out         (start_req)
	);

	// command word fields
	icps_order_decode u_dec (
		.cmd_word_in    (cmd_reg),
		.order_out      (order),
		.chain_flag_out (chain_flag),
		.cond_flag_out  (cond_flag),
		.count_out      (cmd_count)
	);

	// every memory access parks in ST_MEM and returns to ret_reg on ack
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg       <= icps_pkg::ST_IDLE;
			ret_reg         <= icps_pkg::ST_IDLE;
			ptr_reg         <= 16'h0000;
			step_reg        <= 16'h0000;
			cmd_reg         <= 16'h0000;
			oper_reg        <= 16'h0000;
			data_addr_reg   <= 16'h0000;
			count_reg       <= 12'h000;
			mem_addr_reg    <= 16'h0000;
			mem_wdata_reg   <= 16'h0000;
			mem_we_reg      <= 1'b0;
			rdata_reg       <= 16'h0000;
			chain_reg       <= 1'b0;
			xfer_reg        <= 1'b0;
			xfer_read_reg   <= 1'b0;
			start_pulse_reg <= 1'b0;
			ctrl_valid_reg  <= 1'b0;
			ctrl_data_reg   <= 28'h0;
			irq_reg         <= 1'b0;
			done_reg        <= 1'b0;
			wdata_reg       <= 16'h0000;
			dev_latch_reg   <= 8'h00;
		end else begin
			start_pulse_reg <= 1'b0;
			ctrl_valid_reg  <= 1'b0;
			irq_reg         <= 1'b0;
			done_reg        <= 1'b0;
			case (state_reg)
				icps_pkg::ST_IDLE: begin
					if (start_req) begin
						// stack top becomes the program pointer
						dev_latch_reg <= reg_dev_num;
						mem_addr_reg  <= {6'h00, reg_dev_num, 2'b00};
						mem_wdata_reg <= reg_tos;
						mem_we_reg    <= 1'b1;
						ptr_reg       <= reg_tos;
						chain_reg     <= 1'b0;
						xfer_reg      <= 1'b0;
						ret_reg       <= icps_pkg::ST_START;
						state_reg     <= icps_pkg::ST_MEM;
					end
				end
				icps_pkg::ST_MEM: begin
					if (mem_ack_in) begin
						rdata_reg <= mem_rdata_in;
						state_reg <= ret_reg;
					end
				end
				icps_pkg::ST_START: begin
					// controller is told to start; cpu side is already free
					start_pulse_reg <= 1'b1;
					state_reg       <= icps_pkg::ST_DEMAND;
				end
				icps_pkg::ST_DEMAND: begin
					// multiplexer reads the table pointer on each demand,
					// selector reads it itself only once
					if (selector_mode | chan_demand_in) begin
						mem_addr_reg <= table_addr;
						mem_we_reg   <= 1'b0;
						ret_reg      <= icps_pkg::ST_PTR;
						state_reg    <= icps_pkg::ST_MEM;
					end
				end
				icps_pkg::ST_PTR: begin
					ptr_reg      <= rdata_reg;
					step_reg     <= rdata_reg;
					mem_addr_reg <= rdata_reg;
					mem_we_reg   <= 1'b0;
					ret_reg      <= icps_pkg::ST_CMD;
					state_reg    <= icps_pkg::ST_MEM;
				end
				icps_pkg::ST_CMD: begin
					cmd_reg      <= rdata_reg;
					mem_addr_reg <= step_reg + icps_pkg::OPER_OFS;
					ret_reg      <= icps_pkg::ST_OPER;
					state_reg    <= icps_pkg::ST_MEM;
				end
				icps_pkg::ST_OPER: begin
					oper_reg  <= rdata_reg;
					// pointer moves to the next double word
					ptr_reg   <= step_reg + icps_pkg::PTR_STEP;
					state_reg <= icps_pkg::ST_EXEC;
				end
				icps_pkg::ST_EXEC: begin
					state_reg <= icps_pkg::ST_NEXT;
					// a transfer that is not continued by chaining is closed here
					if (!chain_cont)
						xfer_reg <= 1'b0;
					chain_reg <= 1'b0;
					case (order)
						icps_pkg::ORDER_JUMP: begin
							// controller decides only when the condition bit is set
							if (jump_taken)
								ptr_reg <= oper_reg;
						end
						icps_pkg::ORDER_RESIDUE: begin
							// remaining count goes into the operand word
							mem_addr_reg  <= step_reg + icps_pkg::OPER_OFS;
							mem_wdata_reg <= {4'h0, count_reg};
							mem_we_reg    <= 1'b1;
							ret_reg       <= icps_pkg::ST_NEXT;
							state_reg     <= icps_pkg::ST_MEM;
						end
						icps_pkg::ORDER_INTR: begin
							irq_reg <= 1'b1;
						end
						icps_pkg::ORDER_END: begin
							// status into operand word, interrupt only on bit set
							irq_reg       <= cond_flag;
							mem_addr_reg  <= step_reg + icps_pkg::OPER_OFS;
							mem_wdata_reg <= dev_status_in;
							mem_we_reg    <= 1'b1;
							ret_reg       <= icps_pkg::ST_DONE;
							state_reg     <= icps_pkg::ST_MEM;
						end
						icps_pkg::ORDER_CONTROL: begin
							ctrl_valid_reg <= 1'b1;
							ctrl_data_reg  <= {oper_reg, cmd_count};
						end
						icps_pkg::ORDER_SENSE: begin
							mem_addr_reg  <= step_reg + icps_pkg::OPER_OFS;
							mem_wdata_reg <= dev_status_in;
							mem_we_reg    <= 1'b1;
							ret_reg       <= icps_pkg::ST_NEXT;
							state_reg     <= icps_pkg::ST_MEM;
						end
						default: begin
							// negative word count; zero means a full 4096 words
							count_reg     <= cmd_count;
							data_addr_reg <= oper_reg;
							chain_reg     <= chain_flag;
							xfer_reg      <= 1'b1;
							xfer_read_reg <= (order == icps_pkg::ORDER_READ);
							if (order == icps_pkg::ORDER_READ) begin
								state_reg <= icps_pkg::ST_RD_DEV;
							end else begin
								mem_addr_reg <= oper_reg;
								mem_we_reg   <= 1'b0;
								ret_reg      <= icps_pkg::ST_WR_DATA;
								state_reg    <= icps_pkg::ST_MEM;
							end
						end
					endcase
				end
				icps_pkg::ST_WR_DATA: begin
					wdata_reg <= rdata_reg;
					state_reg <= icps_pkg::ST_WR_DEV;
				end
				icps_pkg::ST_WR_DEV: begin
					if (dev_wready_in)
						state_reg <= icps_pkg::ST_XFER_NEXT;
				end
				icps_pkg::ST_RD_DEV: begin
					if (dev_rvalid_in) begin
						mem_addr_reg  <= data_addr_reg;
						mem_wdata_reg <= dev_rdata_in;
						mem_we_reg    <= 1'b1;
						ret_reg       <= icps_pkg::ST_XFER_NEXT;
						state_reg     <= icps_pkg::ST_MEM;
					end
				end
				icps_pkg::ST_XFER_NEXT: begin
					// one step per word, finished when the count wraps to zero
					count_reg     <= count_inc;
					data_addr_reg <= data_addr_reg + 16'h0001;
					if (count_last) begin
						state_reg <= icps_pkg::ST_NEXT;
						if (!chain_reg)
							xfer_reg <= 1'b0;
					end else if (xfer_read_reg) begin
						state_reg <= icps_pkg::ST_RD_DEV;
					end else begin
						mem_addr_reg <= data_addr_reg + 16'h0001;
						mem_we_reg   <= 1'b0;
						ret_reg      <= icps_pkg::ST_WR_DATA;
						state_reg    <= icps_pkg::ST_MEM;
					end
				end
				icps_pkg::ST_NEXT: begin
					// multiplexer keeps the live pointer in the table after every step but the end order
					step_reg <= ptr_reg;
					if (selector_mode) begin
						mem_addr_reg <= ptr_reg;
						mem_we_reg   <= 1'b0;
						ret_reg      <= icps_pkg::ST_CMD;
						state_reg    <= icps_pkg::ST_MEM;
					end else begin
						mem_addr_reg  <= table_addr;
						mem_wdata_reg <= ptr_reg;
						mem_we_reg    <= 1'b1;
						ret_reg       <= icps_pkg::ST_DEMAND;
						state_reg     <= icps_pkg::ST_MEM;
					end
				end
				icps_pkg::ST_DONE: begin
					xfer_reg <= 1'b0;
					if (selector_mode & ~mem_we_reg) begin
						done_reg  <= 1'b1;
						state_reg <= icps_pkg::ST_IDLE;
					end else if (selector_mode) begin
						// selector returns its private pointer to the table
						mem_addr_reg  <= table_addr;
						mem_wdata_reg <= ptr_reg;
						mem_we_reg    <= 1'b0;
						ret_reg       <= icps_pkg::ST_DONE;
						state_reg     <= icps_pkg::ST_MEM;
					end else begin
						done_reg  <= 1'b1;
						state_reg <= icps_pkg::ST_IDLE;
					end
				end
				default: state_reg <= icps_pkg::ST_IDLE;
			endcase
		end
	end

	// the memory write strobe is derived from the access state, so the done-state
	// write-back is issued as a write even though mem_we_reg marks it finished
	wire wb_back = (state_reg == icps_pkg::ST_MEM) & (ret_reg == icps_pkg::ST_DONE) &
		selector_mode & (mem_addr_reg == table_addr) & ~mem_we_reg;

	assign mem_req_out         = (state_reg == icps_pkg::ST_MEM);
	assign mem_we_out          = mem_we_reg | wb_back;
	assign mem_addr_out        = mem_addr_reg;
	assign mem_wdata_out       = mem_wdata_reg;
	assign dev_start_out       = start_pulse_reg;
	assign dev_num_out         = dev_latch_reg;
	assign dev_ctrl_valid_out  = ctrl_valid_reg;
	assign dev_ctrl_data_out   = ctrl_data_reg;
	assign dev_xfer_active_out = xfer_reg;
	assign dev_xfer_read_out   = xfer_read_reg;
	assign dev_wvalid_out      = (state_reg == icps_pkg::ST_WR_DEV);
	assign dev_wdata_out       = wdata_reg;
	assign dev_rready_out      = (state_reg == icps_pkg::ST_RD_DEV);
	assign cpu_irq_out         = irq_reg;
	assign prog_done_out       = done_reg;
endmodule : icps_top

// ===== design/icps_wb_regs.sv
// icps_wb_regs: classic wishbone slave holding the start and mode registers.
// assumes single-cycle classic transfers; ack follows one cycle after the request.
`timescale 1ns/1ps
module icps_wb_regs (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        busy_in,
	input  wire logic        chain_in,
	input  wire logic [15:0] ptr_in,
	input  wire logic [11:0] count_in,
	output logic [7:0]       dev_num_out,
	output logic [15:0]      tos_out,
	output logic             selector_mode_out,
	output logic             start_out
);
	logic [15:0] ctrl_reg;
	logic [15:0] tos_reg;
	logic        mode_reg;
	logic        ack_reg;
	logic        start_reg;
	logic [31:0] rdata_reg;

	wire req      = wb_cyc_in & wb_stb_in & ~ack_reg;
	wire wr_lo    = req & wb_we_in & wb_sel_in[0];
	wire wr_hi    = req & wb_we_in & wb_sel_in[1];
	wire hit_ctrl = (wb_adr_in == icps_pkg::REG_CTRL);
	wire hit_tos  = (wb_adr_in == icps_pkg::REG_TOS);
	wire hit_mode = (wb_adr_in == icps_pkg::REG_MODE);
	wire start_wr = wr_hi & hit_ctrl & ~busy_in &
		(wb_dat_in[icps_pkg::CMD_HI:icps_pkg::CMD_LO] == icps_pkg::START_CMD);
	logic [31:0] rd_mux;

	// unmapped addresses answer with zero data and are otherwise ignored
	always_comb begin
		if (hit_ctrl)
			rd_mux = {16'h0000, ctrl_reg};
		else if (hit_tos)
			rd_mux = {16'h0000, tos_reg};
		else if (hit_mode)
			rd_mux = {31'h0, mode_reg};
		else if (wb_adr_in == icps_pkg::REG_STATUS)
			rd_mux = {30'h0, chain_in, busy_in};
		else if (wb_adr_in == icps_pkg::REG_PTR)
			rd_mux = {16'h0000, ptr_in};
		else if (wb_adr_in == icps_pkg::REG_COUNT)
			rd_mux = {20'h0, count_in};
		else
			rd_mux = 32'h0;
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_reg  <= icps_pkg::CTRL_RST;
			tos_reg   <= icps_pkg::TOS_RST;
			mode_reg  <= icps_pkg::MODE_RST;
			ack_reg   <= 1'b0;
			start_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ack_reg   <= req;
			rdata_reg <= req ? rd_mux : rdata_reg;
			start_reg <= start_wr;
			// device number low byte, start command in bits 14:12
			if (wr_lo & hit_ctrl)
				ctrl_reg[7:0] <= wb_dat_in[7:0];
			if (wr_hi & hit_ctrl)
				ctrl_reg[15:8] <= wb_dat_in[15:8];
			if (wr_lo & hit_tos)
				tos_reg[7:0] <= wb_dat_in[7:0];
			if (wr_hi & hit_tos)
				tos_reg[15:8] <= wb_dat_in[15:8];
			if (wr_lo & hit_mode)
				mode_reg <= wb_dat_in[0];
		end
	end

	assign wb_ack_out        = ack_reg;
	assign wb_dat_out        = rdata_reg;
	assign dev_num_out       = ctrl_reg[7:0];
	assign tos_out           = tos_reg;
	assign selector_mode_out = mode_reg;
	assign start_out         = start_reg;
endmodule : icps_wb_regs

// ===== inc/icps_pkg.sv
// icps_pkg: constants and types shared by the channel program sequencer files.
// assumes 16-bit memory words; field positions use bit 0 as the least significant bit.
package icps_pkg;

	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 16;
	localparam int COUNT_W = 12;
	localparam int DEV_W   = 8;
	localparam int CTRL_W  = DATA_W + COUNT_W;

	// command word layout (leftmost printed bit is bit 15 here)
	localparam int CHAIN_POS = 15;
	localparam int ORDER_HI  = 14;
	localparam int ORDER_LO  = 12;
	localparam int COND_POS  = 11;

	// order codes
	localparam logic [2:0] ORD_JUMP    = 3'h0;
	localparam logic [2:0] ORD_RESIDUE = 3'h1;
	localparam logic [2:0] ORD_INTR    = 3'h2;
	localparam logic [2:0] ORD_END     = 3'h3;
	localparam logic [2:0] ORD_CONTROL = 3'h4;
	localparam logic [2:0] ORD_SENSE   = 3'h5;
	localparam logic [2:0] ORD_WRITE   = 3'h6;
	localparam logic [2:0] ORD_READ    = 3'h7;

	// control register: device number in low byte, command in bits 14:12
	localparam int          CMD_HI    = 14;
	localparam int          CMD_LO    = 12;
	localparam logic [2:0]  START_CMD = 3'h1;

	// device table: entry = device number times four, word 0 is the pointer
	localparam int          TABLE_SHIFT = 2;
	localparam logic [15:0] PTR_STEP    = 16'h0002;
	localparam logic [15:0] OPER_OFS    = 16'h0001;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_TOS    = 8'h04;
	localparam logic [7:0] REG_MODE   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_PTR    = 8'h10;
	localparam logic [7:0] REG_COUNT  = 8'h14;

	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] TOS_RST  = 16'h0000;
	localparam logic        MODE_RST = 1'b0;

	typedef enum logic [2:0] {
		ORDER_JUMP, ORDER_RESIDUE, ORDER_INTR, ORDER_END,
		ORDER_CONTROL, ORDER_SENSE, ORDER_WRITE, ORDER_READ
	} icps_order_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_MEM, ST_START, ST_DEMAND, ST_PTR, ST_CMD, ST_OPER, ST_EXEC,
		ST_WR_DATA, ST_WR_DEV, ST_RD_DEV, ST_XFER_NEXT, ST_NEXT, ST_DONE
	} icps_state_t;

endpackage : icps_pkg

// ===== test/icps_partner.sv
// icps_partner: main memory and device controller model on the far side.
// assumes one access at a time; answers every other cycle so waits are exercised.
`timescale 1ns/1ps
module icps_partner (
	input  wire logic        core_clk_in,
	input  wire logic        mem_req_in,
	input  wire logic        mem_we_in,
	input  wire logic [15:0] mem_addr_in,
	input  wire logic [15:0] mem_wdata_in,
	output logic [15:0]      mem_rdata_out,
	output logic             mem_ack_out,
	input  wire logic        wvalid_in,
	input  wire logic [15:0] wdata_in,
	output logic             wready_out,
	input  wire logic        rready_in,
	output logic             rvalid_out,
	output logic [15:0]      rdata_out
);
	logic [15:0] mem [256];
	logic [15:0] wq [$];
	logic [15:0] n_rd = 16'h0000;
	initial mem_ack_out = 1'b0;
	initial wready_out = 1'b0;
	initial rvalid_out = 1'b0;
	// released lines show the inverse so a late sample cannot pass
	assign mem_rdata_out = mem_ack_out ? mem[mem_addr_in[7:0]] : ~mem[mem_addr_in[7:0]];
	assign rdata_out = rvalid_out ? 16'hd000 + n_rd : ~(16'hd000 + n_rd);
	always @(posedge core_clk_in) begin
		mem_ack_out <= mem_req_in && !mem_ack_out;
		wready_out <= !wready_out;
		rvalid_out <= !rvalid_out;
		if (mem_req_in && mem_ack_out && mem_we_in)
			mem[mem_addr_in[7:0]] <= mem_wdata_in;
		if (wvalid_in && wready_out)
			wq.push_back(wdata_in);
		if (rready_in && rvalid_out)
			n_rd <= n_rd + 16'h0001;
	end
endmodule : icps_partner

// ===== test/icps_props.sv
// icps_props: port-level protocol checks for the sequencer top.
// assumes a bind from the bench top; rst_in is asynchronous, active high.
`timescale 1ns/1ps
module icps_props (
	input wire logic        core_clk_in,
	input wire logic        rst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_ack_out,
	input wire logic        mem_req_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic        mem_ack_in,
	input wire logic        dev_start_out,
	input wire logic        dev_ctrl_valid_out,
	input wire logic        dev_wvalid_out,
	input wire logic [15:0] dev_wdata_out,
	input wire logic        dev_wready_in,
	input wire logic        cpu_irq_out,
	input wire logic        prog_done_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_mem_wait;
		mem_req_out && !mem_ack_in;
	endsequence
	sequence s_mem_end;
		mem_req_out && mem_ack_in;
	endsequence
	a_wb_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("register ack missing");
	a_wb_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("register ack too long");
	a_mem_hold: assert property (s_mem_wait |=> mem_req_out && $stable(mem_addr_out))
		else $error("memory request dropped early");
	a_mem_gap: assert property (s_mem_end |=> !mem_req_out) else $error("no gap after memory ack");
	a_start_pulse: assert property (dev_start_out |=> !dev_start_out) else $error("start pulse long");
	a_ctrl_pulse: assert property (dev_ctrl_valid_out |=> !dev_ctrl_valid_out) else $error("ctrl long");
	a_wdata_hold: assert property (dev_wvalid_out && !dev_wready_in |=>
		dev_wvalid_out && $stable(dev_wdata_out)) else $error("write word not held");
	a_irq_pulse: assert property (cpu_irq_out |=> !cpu_irq_out) else $error("irq pulse long");
	a_done_pulse: assert property (prog_done_out |=> !prog_done_out) else $error("done pulse long");
endmodule : icps_props

// ===== test/icps_tb_top.sv
// icps_tb_top: runs a selector program over every order, then a multiplexer program.
// assumes icps_partner answers memory and device traffic; status is fixed, conditional jumps refused.
`timescale 1ns/1ps
module icps_tb_top;
	logic core_clk_in = 1'b0, rst_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, xa_q = 1'b0;
	logic [7:0] wb_adr_in = 8'h00, dev_num_out;
	logic [3:0] wb_sel_in = 4'h3;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
	logic wb_ack_out, mem_req_out, mem_we_out, mem_ack_in, chan_demand_in = 1'b0, dev_start_out;
	logic [15:0] mem_addr_out, mem_wdata_out, mem_rdata_in, dev_wdata_out, dev_rdata_in;
	logic dev_ctrl_valid_out, dev_xfer_active_out, dev_xfer_read_out, dev_wvalid_out, dev_wready_in;
	logic dev_rvalid_in, dev_rready_out, cpu_irq_out, prog_done_out;
	logic [27:0] dev_ctrl_data_out, ctrl_seen = 28'h0;
	int n_errors = 0, cmp_count = 0, n_irq = 0, n_done = 0, n_st = 0, n_up = 0, n_dir = 0;
	always #25 core_clk_in = ~core_clk_in;
	icps_top u_dut (.core_clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
		.wb_dat_in, .wb_dat_out, .wb_ack_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
		.mem_rdata_in, .mem_ack_in, .chan_demand_in, .dev_start_out, .dev_num_out, .dev_jump_ok_in(1'b0),
		.dev_status_in(16'h5a5a), .dev_ctrl_valid_out, .dev_ctrl_data_out, .dev_xfer_active_out,
		.dev_xfer_read_out, .dev_wvalid_out, .dev_wdata_out, .dev_wready_in, .dev_rvalid_in,
		.dev_rdata_in, .dev_rready_out, .cpu_irq_out, .prog_done_out);
	icps_partner u_part (.core_clk_in, .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in),
		.mem_ack_out(mem_ack_in), .wvalid_in(dev_wvalid_out), .wdata_in(dev_wdata_out),
		.wready_out(dev_wready_in), .rready_in(dev_rready_out), .rvalid_out(dev_rvalid_in),
		.rdata_out(dev_rdata_in));
	always @(posedge core_clk_in) begin
		if (cpu_irq_out) n_irq <= n_irq + 1;
		if (prog_done_out) n_done <= n_done + 1;
		if (dev_ctrl_valid_out) ctrl_seen <= dev_ctrl_data_out;
		if (dev_start_out) n_st <= n_st + 1;
		xa_q <= dev_xfer_active_out;
		if (dev_xfer_active_out && !xa_q) n_up <= n_up + 1;
		if (dev_wvalid_out && dev_wready_in && !dev_xfer_read_out ||
			dev_rready_out && dev_rvalid_in && dev_xfer_read_out) n_dir <= n_dir + 1;
	end
	task automatic summarize;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int i;
		@(posedge core_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= adr;
		wb_dat_in <= d;
		i = 0;
		do begin
			@(posedge core_clk_in);
			i++;
		end while (wb_ack_out !== 1'b1 && i < 50);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		if (wb_ack_out !== 1'b1) begin
			n_errors++;
			summarize();
		end
	endtask : wb
	task automatic ld(input logic [7:0] a, input logic [15:0] cw, input logic [15:0] op);
		u_part.mem[a] = cw;
		u_part.mem[a + 8'h01] = op;
	endtask : ld
	// multiplexer waits for channel demand
	task automatic run(input logic [31:0] mode, input logic [31:0] top_of_stack, input logic [31:0] ctl);
		int d;
		d = n_done;
		wb(1'b1, 8'h08, mode);
		wb(1'b1, 8'h04, top_of_stack);
		wb(1'b1, 8'h00, ctl);
		if (mode == 32'h0) begin
			repeat (30) @(posedge core_clk_in);
			chk("early end", 28'(d), 28'(n_done));
			chan_demand_in <= 1'b1;
		end
		for (int i = 0; i < 3000 && d == n_done; i++) @(posedge core_clk_in);
		if (d == n_done) begin
			n_errors++;
			summarize();
		end
	endtask : run
	initial begin
		for (int a = 0; a < 256; a++) u_part.mem[a] = 16'h0000;
		ld(8'h40, 16'h0000, 16'h0050);
		ld(8'h50, 16'h4abc, 16'h1234);
		ld(8'h52, 16'heffe, 16'h0080);
		ld(8'h54, 16'h6fff, 16'h0090);
		ld(8'h56, 16'h7ffe, 16'h00a0);
		ld(8'h58, 16'h5000, 16'hffff);
		ld(8'h5a, 16'h1000, 16'hffff);
		ld(8'h5c, 16'h2000, 16'h0000);
		ld(8'h5e, 16'h0800, 16'h0070);
		ld(8'h60, 16'h3800, 16'hffff);
		ld(8'h70, 16'h3000, 16'h0000);
		ld(8'h20, 16'h2000, 16'hffff);
		ld(8'h22, 16'h3000, 16'h0000);
		ld(8'h80, 16'h1111, 16'h2222);
		ld(8'h90, 16'h3333, 16'h0000);
		repeat (20) @(posedge core_clk_in);
		rst_in <= 1'b0;
		wb(1'b0, 8'h3c, 32'h0);
		chk("unmapped", 28'h0, q[27:0]);
		run(32'h1, 32'h40, 32'h1003);
		chk("device", 28'h3, 28'(dev_num_out));
		chk("ctrl", 28'h1234abc, ctrl_seen);
		chk("wr count", 28'h3, 28'(u_part.wq.size()));
		chk("wr0", 28'h1111, 28'(u_part.wq[0]));
		chk("wr2", 28'h3333, 28'(u_part.wq[2]));
		chk("rd0", 28'hd000, 28'(u_part.mem[8'ha0]));
		chk("rd1", 28'hd001, 28'(u_part.mem[8'ha1]));
		chk("sense", 28'h5a5a, 28'(u_part.mem[8'h59]));
		chk("residue", 28'h0, 28'(u_part.mem[8'h5b]));
		chk("end", 28'h5a5a, 28'(u_part.mem[8'h61]));
		chk("irq", 28'h2, 28'(n_irq));
		chk("runs", 28'h2, 28'(n_up));
		chk("words", 28'h5, 28'(n_dir));
		chk("ptr", 28'h62, 28'(u_part.mem[8'h0c]));
		run(32'h0, 32'h20, 32'h1005);
		chk("mux end", 28'h5a5a, 28'(u_part.mem[8'h23]));
		chk("irq", 28'h3, 28'(n_irq));
		chk("mptr", 28'h22, 28'(u_part.mem[8'h14]));
		chk("starts", 28'h2, 28'(n_st));
		summarize();
	end
endmodule : icps_tb_top
bind icps_top icps_props u_props (.core_clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .mem_req_out,
	.mem_addr_out, .mem_ack_in, .dev_start_out, .dev_ctrl_valid_out, .dev_wvalid_out, .dev_wdata_out,
	.dev_wready_in, .cpu_irq_out, .prog_done_out);
